/* File: inc/asq_pkg.sv */
package asq_pkg;

    // Serial command word layout
    localparam int FRAME_BITS = 16;
    localparam int CMD_WRITE_BIT = 15;
    localparam int ADDR_MSB = 14;
    localparam int ADDR_LSB = 9;
    localparam int DATA_MSB = 8;
    localparam int DATA_LSB = 0;
    localparam logic [15:0] EXIT_REG_MODE_WORD = 16'h8000;
    localparam logic [15:0] NOP_WORD = 16'h0000;

    // Register map
    localparam logic [5:0] ADDR_EXIT = 6'h00;
    localparam logic [5:0] ADDR_CONFIG = 6'h02;
    localparam logic [5:0] ADDR_CHANNEL = 6'h03;
    localparam logic [5:0] ADDR_STACK_BASE = 6'h20;
    localparam logic [8:0] REG_RESET_VAL = 9'h000;
    localparam logic [8:0] RANGE_RESET_VAL = 9'h0FF;
    localparam logic [5:0] ADDR_RANGE_FIRST = 6'h04;
    localparam logic [5:0] ADDR_RANGE_LAST = 6'h07;

    // Configuration register fields
    localparam int CFG_BURST_BIT = 6;
    localparam int CFG_SEQUENCER_ENABLE_BIT = 5;

    // Channel register and stack register fields
    localparam int SEL_A_LSB = 0;
    localparam int SEL_B_LSB = 4;
    localparam int SEL_W = 4;
    localparam int STACK_LAST_BIT = 8;

    // Sequencer geometry
    localparam int STACK_DEPTH = 32;
    localparam int STEP_W = 5;
    localparam int NUM_REGS = 64;

    // Cycles after reset release before straps are taken (sync latency)
    localparam logic [1:0] STRAP_DELAY = 2'h3;

    typedef struct packed {
        logic [15:0] a;
        logic [15:0] b;
    } asq_pair_t;

    typedef struct packed {
        logic [SEL_W-1:0] a;
        logic [SEL_W-1:0] b;
    } asq_sel_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_START = 2'h1,
        ST_WAIT = 2'h3
    } asq_state_t;

endpackage

/* File: logic/asq_pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module asq_pin_sync #(
    parameter logic RST_VAL = 1'b0
) (
    // Clocking
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    // Pin and its settled level
    input wire logic pin_in,
    output logic level
);
    logic s1;
    logic s2;
    logic s3;

    // Stages run through reset so straps have settled by release
    always_ff @(posedge clk_sys)
    begin
        if (ce)
        begin
            s1 <= pin_in;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // Level changes only once two stages agree, filtering one-cycle glitches
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            level <= RST_VAL;
        else if (ce && s2 == s3)
            level <= s3;
    end
endmodule // asq_pin_sync
`default_nettype wire

/* File: logic/asq_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
module asq_sequencer
    import asq_pkg::*;
(
    // Clocking
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    // Mode and strap pins
    input wire logic hw_mode,
    input wire logic sequencer_enable,
    input wire logic burst_pin,
    input wire logic [2:0] channel_range_select,
    input wire logic partial_reset,
    // Host serial link and convert start
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic sdi,
    input wire logic convert_start,
    output logic serial_out_a,
    output logic serial_out_b,
    output logic serial_oe,
    output logic busy,
    // Converter core
    output logic conv_req,
    output logic [SEL_W-1:0] a_channel_select,
    output logic [SEL_W-1:0] b_channel_select,
    input wire logic conv_done,
    input wire asq_pair_t conv_result
);
    logic cs_n_s, sclk_s, sdi_s, cst_s, pr_s, seq_pin_s, burst_pin_s, hw_mode_s;
    logic [2:0] range_s;
    logic cs_n_q, sclk_q, cst_q, pr_q;

    asq_pin_sync #(.RST_VAL(1'b1)) u_cs (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
        .pin_in(cs_n), .level(cs_n_s));
    asq_pin_sync u_sclk (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
        .pin_in(sclk), .level(sclk_s));
    asq_pin_sync u_sdi (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
        .pin_in(sdi), .level(sdi_s));
    asq_pin_sync u_cst (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
        .pin_in(convert_start), .level(cst_s));
    asq_pin_sync u_pr (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
        .pin_in(partial_reset), .level(pr_s));
    asq_pin_sync u_seq (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
        .pin_in(sequencer_enable), .level(seq_pin_s));
    asq_pin_sync u_bst (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
        .pin_in(burst_pin), .level(burst_pin_s));
    asq_pin_sync u_hwm (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
        .pin_in(hw_mode), .level(hw_mode_s));

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_range
            asq_pin_sync u_rng (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
                .pin_in(channel_range_select[gi]), .level(range_s[gi]));
        end
    endgenerate

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            cs_n_q <= 1'b1;
            sclk_q <= 1'b0;
            cst_q <= 1'b0;
            pr_q <= 1'b0;
        end
        else if (ce)
        begin
            cs_n_q <= cs_n_s;
            sclk_q <= sclk_s;
            cst_q <= cst_s;
            pr_q <= pr_s;
        end
    end

    wire logic cs_fall = ce && cs_n_q && !cs_n_s;
    wire logic sclk_rise = ce && !cs_n_s && sclk_s && !sclk_q;
    wire logic cst_rise = ce && cst_s && !cst_q;
    wire logic pr_rise = ce && pr_s && !pr_q;

    // Straps: caught once the synchronisers have settled after release
    logic [1:0] strap_cnt;
    logic strap_done, hw_seq_en, hw_burst, hw_mode_q;
    logic [2:0] hw_range, range_pend;
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            strap_cnt <= 2'h0;
            strap_done <= 1'b0;
            hw_seq_en <= 1'b0;
            hw_burst <= 1'b0;
            hw_mode_q <= 1'b0;
        end
        else if (ce && !strap_done)
        begin
            strap_cnt <= strap_cnt + 2'h1;
            if (strap_cnt == STRAP_DELAY)
            begin
                strap_done <= 1'b1;
                hw_mode_q <= hw_mode_s;
                hw_seq_en <= seq_pin_s;
                hw_burst <= seq_pin_s && burst_pin_s;
            end
        end
    end

    // Register file and serial command handling
    logic [8:0] regs [NUM_REGS];
    logic [15:0] shift_in;
    logic [15:0] shift_a, shift_b;
    logic [4:0] bit_cnt;
    logic frame_done;
    logic reg_mode;
    logic [5:0] prev_addr;
    logic [STEP_W-1:0] rd_idx;
    asq_pair_t res_buf [STACK_DEPTH];

    wire logic [15:0] next_word = {shift_in[14:0], sdi_s};
    wire logic word_end = sclk_rise && bit_cnt == 5'(FRAME_BITS - 1);
    wire logic [5:0] cmd_addr = next_word[ADDR_MSB:ADDR_LSB];
    wire logic cmd_write = next_word[CMD_WRITE_BIT];
    wire logic sw_cmd = word_end && !hw_mode_q;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            bit_cnt <= 5'h00;
            shift_in <= 16'h0000;
            frame_done <= 1'b0;
        end
        else if (ce)
        begin
            frame_done <= word_end;
            if (cs_fall || word_end)
                bit_cnt <= 5'h00;
            else if (sclk_rise)
                bit_cnt <= bit_cnt + 5'h01;
            if (sclk_rise)
                shift_in <= next_word;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < NUM_REGS; i++)
                regs[i] <= (6'(i) >= ADDR_RANGE_FIRST && 6'(i) <= ADDR_RANGE_LAST) ?
                    RANGE_RESET_VAL : REG_RESET_VAL;
        end
        else if (sw_cmd && cmd_write)
            regs[cmd_addr] <= next_word[DATA_MSB:DATA_LSB];
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            reg_mode <= 1'b0;
            prev_addr <= 6'h00;
        end
        else if (sw_cmd)
        begin
            prev_addr <= cmd_addr;
            if (next_word == EXIT_REG_MODE_WORD)
                reg_mode <= 1'b0;
            else if (next_word != NOP_WORD)
                reg_mode <= 1'b1;
        end
    end

    // Outgoing word loaded at chip select fall and after every frame
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            shift_a <= 16'h0000;
            shift_b <= 16'h0000;
            serial_oe <= 1'b0;
        end
        else if (ce)
        begin
            serial_oe <= !cs_n_s;
            if (cs_fall || frame_done)
            begin
                if (reg_mode)
                begin
                    shift_a <= {1'b0, 6'h00, regs[prev_addr]};
                    shift_b <= {1'b0, 6'h00, regs[prev_addr]};
                end
                else
                begin
                    shift_a <= res_buf[rd_idx].a;
                    shift_b <= res_buf[rd_idx].b;
                end
            end
            else if (sclk_rise)
            begin
                shift_a <= {shift_a[14:0], 1'b0};
                shift_b <= {shift_b[14:0], 1'b0};
            end
        end
    end
    assign serial_out_a = shift_a[15];
    assign serial_out_b = shift_b[15];

    // Sequencer configuration
    wire logic [8:0] cfg = regs[ADDR_CONFIG];
    wire logic seq_en = hw_mode_q ? hw_seq_en : cfg[CFG_SEQUENCER_ENABLE_BIT];
    wire logic burst_en = hw_mode_q ? hw_burst :
        (cfg[CFG_BURST_BIT] && cfg[CFG_SEQUENCER_ENABLE_BIT]);
    logic [STEP_W-1:0] step;
    wire logic [8:0] stack_ent = regs[ADDR_STACK_BASE + 6'(step)];
    wire logic last_step = !seq_en ? 1'b1 :
        hw_mode_q ? (step == STEP_W'(hw_range)) :
        stack_ent[STACK_LAST_BIT];

    asq_sel_t next_sel;
    always_comb
    begin
        next_sel.a = regs[ADDR_CHANNEL][SEL_A_LSB +: SEL_W];
        next_sel.b = regs[ADDR_CHANNEL][SEL_B_LSB +: SEL_W];
        if (hw_mode_q)
        begin
            next_sel.a = seq_en ? SEL_W'(step) : 4'h0;
            next_sel.b = seq_en ? SEL_W'(step) : 4'h0;
        end
        else if (seq_en)
        begin
            next_sel.a = stack_ent[SEL_A_LSB +: SEL_W];
            next_sel.b = stack_ent[SEL_B_LSB +: SEL_W];
        end
    end

    // Conversion control
    asq_state_t state;
    logic [STEP_W-1:0] seq_cnt;
    wire logic store = ce && state == ST_WAIT && conv_done;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            state <= ST_IDLE;
            busy <= 1'b0;
            conv_req <= 1'b0;
            seq_cnt <= '0;
            a_channel_select <= 4'h0;
            b_channel_select <= 4'h0;
        end
        else if (ce)
        begin
            conv_req <= 1'b0;
            case (state)
                ST_IDLE:
                    if (cst_rise && strap_done)
                    begin
                        state <= ST_START;
                        busy <= 1'b1;
                        seq_cnt <= '0;
                    end
                ST_START:
                begin
                    conv_req <= 1'b1;
                    a_channel_select <= next_sel.a;
                    b_channel_select <= next_sel.b;
                    state <= ST_WAIT;
                end
                ST_WAIT:
                    if (conv_done)
                    begin
                        seq_cnt <= seq_cnt + 1'b1;
                        if (burst_en && !last_step)
                            state <= ST_START;
                        else
                        begin
                            state <= ST_IDLE;
                            busy <= 1'b0;
                        end
                    end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    // Results kept in conversion order for burst readback
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < STACK_DEPTH; i++)
                res_buf[i] <= '0;
        end
        else if (store)
            res_buf[seq_cnt] <= conv_result;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            rd_idx <= '0;
        else if (store)
            rd_idx <= '0;
        // Advance at word end so a held select reloads the next result
        else if (word_end && !reg_mode)
            rd_idx <= rd_idx + 1'b1;
    end

    // Step pointer; partial reset touches nothing else
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            step <= '0;
        else if (pr_rise)
            step <= '0;
        else if (store && seq_en)
            step <= last_step ? '0 : step + 1'b1;
    end

    // Range pins seen during the last busy apply to the next sequence
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            hw_range <= 3'h0;
            range_pend <= 3'h0;
        end
        else if (ce)
        begin
            if (!strap_done)
                hw_range <= range_s;
            else if (store && last_step)
                hw_range <= range_pend;
            if (busy)
                range_pend <= range_s;
        end
    end

    sequence s_step_end;
        store && seq_en && !pr_rise;
    endsequence

    a_write_stores: assert property (@(posedge clk_sys) disable iff (!rst_n)
        sw_cmd && cmd_write |=> regs[$past(cmd_addr)] == $past(next_word[8:0]))
        else $error("write frame data not stored");
    a_exit_reg_mode: assert property (@(posedge clk_sys) disable iff (!rst_n)
        sw_cmd && next_word == EXIT_REG_MODE_WORD |=> !reg_mode)
        else $error("register mode not left");
    a_read_zero_addr: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ce && (cs_fall || frame_done) && reg_mode |=> shift_a[14:9] == 6'h00)
        else $error("readback address bits not zero");
    a_hw_ascending: assert property (@(posedge clk_sys) disable iff (!rst_n)
        conv_req && hw_mode_q && seq_en |-> a_channel_select == SEL_W'(step)
        && b_channel_select == a_channel_select)
        else $error("hardware pair not ascending");
    a_step_wrap: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_step_end ##0 last_step |=> step == 0)
        else $error("step did not wrap");
    a_step_advance: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_step_end ##0 !last_step |=> step == $past(step) + 1'b1)
        else $error("step did not advance");
    a_partial_rewind: assert property (@(posedge clk_sys) disable iff (!rst_n)
        pr_rise |=> step == 0 && regs[ADDR_CONFIG] == $past(regs[ADDR_CONFIG]))
        else $error("partial reset misbehaved");
    a_burst_chain: assert property (@(posedge clk_sys) disable iff (!rst_n)
        store && burst_en && !last_step |=> busy && state == ST_START ##1 conv_req)
        else $error("burst did not chain");
    a_single_step: assert property (@(posedge clk_sys) disable iff (!rst_n)
        store && !burst_en |=> !busy)
        else $error("non-burst busy stuck");
    a_start_busy: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state == ST_IDLE && cst_rise && strap_done |=> busy ##1 conv_req)
        else $error("start edge ignored");
    a_cs_drive: assert property (@(posedge clk_sys) disable iff (!rst_n)
        cs_fall |=> serial_oe)
        else $error("output not released at select");
endmodule // asq_sequencer
`default_nettype wire

/* File: tb/asq_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module asq_host_model (
    // Serial link
    output logic cs_n,
    output logic sclk,
    output logic sdi,
    input wire logic serial_out_a,
    input wire logic serial_out_b,
    input wire logic serial_oe,
    // Strobes
    input wire logic clk_sys,
    output logic convert_start,
    output logic partial_reset
);
    initial
    begin
        cs_n = 1'b1;
        sclk = 1'b0;
        sdi = 1'b0;
        convert_start = 1'b0;
        partial_reset = 1'b0;
    end

    // Phase offset keeps link edges away from the system clock edges
    task automatic frame(input logic [15:0] w, input bit hold, output logic [15:0] ra,
        output logic [15:0] rb, output logic oe);
        #7;
        if (cs_n)
        begin
            cs_n = 1'b0;
            #320;
        end
        oe = 1'b0;
        for (int i = 15; i >= 0; i--)
        begin
            sdi = w[i];
            #160;
            if (i == 15)
                oe = serial_oe;
            ra[i] = serial_out_a;
            rb[i] = serial_out_b;
            sclk = 1'b1;
            #160;
            sclk = 1'b0;
        end
        if (!hold)
        begin
            #160;
            cs_n = 1'b1;
            sdi = ~sdi;
            #320;
        end
    endtask

    // Long enough for the pin synchronisers
    task automatic strobe(input bit conv);
        @(negedge clk_sys);
        convert_start = conv;
        partial_reset = !conv;
        repeat (6) @(negedge clk_sys);
        convert_start = 1'b0;
        partial_reset = 1'b0;
        repeat (2) @(negedge clk_sys);
    endtask
endmodule // asq_host_model
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("mismatch at %0t: got %h exp %h", $time, (g), (e)); end end
module tb;
    import asq_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic hw_mode = 1'b0;
    logic sequencer_enable = 1'b0;
    logic burst_pin = 1'b0;
    logic [2:0] channel_range_select = 3'h0;
    logic cs_n, sclk, sdi, convert_start, partial_reset;
    logic serial_out_a, serial_out_b, serial_oe, busy, conv_req;
    logic conv_done = 1'b0;
    logic [SEL_W-1:0] a_channel_select, b_channel_select;
    asq_pair_t conv_result = '0;
    int miscompares = 0;
    int total_checks = 0;
    logic [31:0] seed = 32'h61C4;
    logic [7:0] exp_sel[$];
    asq_pair_t res_q[$];
    logic [7:0] e8;
    logic [3:0] seq_a[32], seq_b[32];
    logic [8:0] regs[64];
    int seq_len, ptr;
    int new_range = -1;
    logic [15:0] ra, rb;
    logic [5:0] a1, a2;
    logic oe, burst;
    logic [4:0] hwc[4] = '{5'h1A, 5'h17, 5'h0F, 5'h18};

    always #20 clk_sys = ~clk_sys;

    asq_sequencer asq_sequencer_inst (
        .clk_sys(clk_sys), .rst_n(rst_n), .ce(1'b1), .hw_mode(hw_mode),
        .sequencer_enable(sequencer_enable), .burst_pin(burst_pin),
        .channel_range_select(channel_range_select), .partial_reset(partial_reset),
        .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .convert_start(convert_start),
        .serial_out_a(serial_out_a), .serial_out_b(serial_out_b), .serial_oe(serial_oe),
        .busy(busy), .conv_req(conv_req), .a_channel_select(a_channel_select),
        .b_channel_select(b_channel_select), .conv_done(conv_done), .conv_result(conv_result)
    );
    asq_host_model asq_host_model_inst (
        .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .serial_out_a(serial_out_a),
        .serial_out_b(serial_out_b), .serial_oe(serial_oe), .clk_sys(clk_sys),
        .convert_start(convert_start), .partial_reset(partial_reset)
    );

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [5:0] pick(input logic [31:0] s);
        return s[0] ? {1'b1, s[5:1]} : 6'h03 + {4'h0, s[2:1]};
    endfunction

    // Converter core stand-in; varying latency stretches busy unevenly
    initial
    forever
    begin
        @(posedge clk_sys);
        if (conv_req === 1'b1)
        begin
            `CHK(exp_sel.size() > 0, 1'b1)
            e8 = exp_sel.pop_front();
            `CHK({a_channel_select, b_channel_select}, e8)
            seed = lfsr(seed);
            repeat (6 + seed[2:0]) @(negedge clk_sys);
            conv_result = {4'hA, seed[11:0], 4'hB, seed[23:12]};
            res_q.push_back(conv_result);
            conv_done = 1'b1;
            @(negedge clk_sys);
            conv_done = 1'b0;
        end
    end

    task automatic xfer(input logic [15:0] w, input bit hold);
        asq_host_model_inst.frame(w, hold, ra, rb, oe);
        `CHK(oe, 1'b1)
    endtask
    task automatic wr(input logic [5:0] a, input logic [8:0] d);
        regs[a] = d;
        xfer({1'b1, a, d}, 1'b0);
    endtask
    task automatic rd_chk(input logic [5:0] a);
        xfer({1'b0, a, 9'h000}, 1'b1);
        xfer(NOP_WORD, 1'b0);
        `CHK(ra, {7'h00, regs[a]})
        `CHK(rb, {7'h00, regs[a]})
    endtask
    task automatic do_reset(input bit hw, input bit seq, input bit bst, input logic [2:0] n);
        @(negedge clk_sys);
        hw_mode = hw;
        sequencer_enable = seq;
        burst_pin = bst;
        channel_range_select = n;
        rst_n = 1'b0;
        repeat (5) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (12) @(negedge clk_sys);
        for (int i = 0; i < 64; i++)
            regs[i] = (i >= ADDR_RANGE_FIRST && i <= ADDR_RANGE_LAST) ?
                RANGE_RESET_VAL : REG_RESET_VAL;
        for (int i = 0; i < 8; i++)
            {seq_a[i], seq_b[i]} = {i[3:0], i[3:0]};
        seq_len = seq ? n + 1 : 1;
        ptr = 0;
    endtask
    task automatic prog(input int depth, input logic [8:0] cfg);
        for (int i = 0; i < depth; i++)
        begin
            seed = lfsr(seed);
            {seq_b[i], seq_a[i]} = seed[7:0];
            wr(ADDR_STACK_BASE + i[5:0], {i == depth - 1, seed[7:0]});
        end
        wr(ADDR_CONFIG, cfg);
        xfer(EXIT_REG_MODE_WORD, 1'b0);
        seq_len = depth;
        ptr = 0;
    endtask
    task automatic conv(input int steps, input int starts, input bit hold);
        asq_pair_t r;
        for (int s = 0; s < starts; s++)
        begin
            for (int i = 0; i < steps; i++)
            begin
                exp_sel.push_back({seq_a[ptr], seq_b[ptr]});
                ptr = (ptr + 1) % seq_len;
            end
            asq_host_model_inst.strobe(1'b1);
            `CHK(busy, 1'b1)
            if (new_range >= 0)
                channel_range_select = new_range[2:0];
            for (int w = 0; w < 3000 && busy !== 1'b0; w++)
                @(negedge clk_sys);
            `CHK(busy, 1'b0)
            `CHK(exp_sel.size(), 0)
            for (int i = 0; i < steps; i++)
            begin
                xfer(NOP_WORD, hold && i < steps - 1);
                r = res_q.pop_front();
                `CHK(ra, r.a)
                `CHK(rb, r.b)
            end
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        #2000000;
        miscompares++;
        $display("mismatch at %0t: watchdog expired", $time);
        end_of_test();
    end

    initial
    begin
        do_reset(1'b0, 1'b0, 1'b0, 3'h0);
        rd_chk(ADDR_CONFIG);
        rd_chk(ADDR_RANGE_FIRST);
        for (int i = 0; i < 6; i++)
        begin
            seed = lfsr(seed);
            a1 = pick(seed);
            a2 = pick(seed >> 8);
            regs[a1] = seed[24:16];
            xfer({1'b1, a1, regs[a1]}, 1'b1);
            xfer({1'b0, a2, seed[31:23]}, 1'b1);
            `CHK(ra, {7'h00, regs[a1]})
            xfer(NOP_WORD, 1'b0);
            `CHK(rb, {7'h00, regs[a2]})
        end
        xfer(EXIT_REG_MODE_WORD, 1'b0);
        $display("test registers finished");
        prog(32, 9'h060);
        conv(32, 1, 1'b1);
        prog(5, 9'h060);
        conv(5, 2, 1'b0);
        $display("test burst finished");
        prog(5, 9'h020);
        conv(1, 7, 1'b0);
        asq_host_model_inst.strobe(1'b0);
        ptr = 0;
        rd_chk(ADDR_STACK_BASE);
        xfer(EXIT_REG_MODE_WORD, 1'b0);
        conv(1, 1, 1'b0);
        $display("test stepping finished");
        seed = lfsr(seed);
        wr(ADDR_CHANNEL, {1'b0, seed[7:0]});
        {seq_b[0], seq_a[0]} = seed[7:0];
        prog(0, 9'h040);
        seq_len = 1;
        conv(1, 2, 1'b0);
        $display("test single finished");
        for (int k = 0; k < 4; k++)
        begin
            do_reset(1'b1, hwc[k][4], hwc[k][3], hwc[k][2:0]);
            burst = hwc[k][4] && hwc[k][3];
            if (k == 0)
            begin
                new_range = 5;
                conv(seq_len, 1, 1'b0);
                new_range = -1;
                seq_len = 6;
            end
            conv(burst ? seq_len : 1, burst ? 1 : seq_len + 1, 1'b1);
        end
        $display("test hardware finished");
        end_of_test();
    end
endmodule // tb
`default_nettype wire
